// file: hdl/spinning_motor_speed_search.sv
`timescale 1ns/1ps
module spinning_motor_speed_search
  import spinning_catch_pkg::*;
#(
  parameter int unsigned TIME_UNIT_CYC = TIME_UNIT_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        cfgWrite,
  input  wire catch_cfg_t  cfgIn,
  input  wire logic        machineIsInduction,
  input  wire logic        vectorMode,
  input  wire logic        startRequest,
  input  wire logic        stopRequest,
  input  wire logic        stopUncontrolled,
  input  wire logic        setpointReverse,
  input  wire logic [15:0] maxFreq,
  input  wire logic        motorRegenerating,
  output catch_cfg_t       cfgOut,
  output drive_cmd_t       driveCmd,
  output logic       [3:0] motor_sequencer_state,
  output logic             catchActive,
  output logic             rampFromZero,
  output logic             catchSucceeded
);

  typedef enum logic [2:0] {
    ST_STOPPED,
    ST_SEARCH,
    ST_REFLUX,
    ST_RUN
  } seq_state_t;

  seq_state_t  state_reg;
  catch_cfg_t  cfg_reg;
  logic        powerUp_reg;
  logic        lastTrip_reg;
  logic        secondPass_reg;
  logic        regenPrev_reg;
  logic [39:0] acc_reg;
  dda_t        dda_next;
  logic [39:0] sweepLimit;
  logic [39:0] refluxLimit;
  logic [15:0] minDeci;
  logic        catchAllowed;
  logic        triggerMet;
  logic        regenEdge;
  logic        belowMin;
  catch_cfg_t  cfg_next;

  // Shared rate generator: ticks inc times per limit cycles
  function automatic dda_t ddaStep(input logic [39:0] acc,
                                   input logic [15:0] inc,
                                   input logic [39:0] lim);
    dda_t        r;
    logic [39:0] sum;
    sum = acc + {24'h000000, inc};
    if (sum >= lim) begin
      r.acc  = sum - lim;
      r.tick = 1'b1;
    end else begin
      r.acc  = sum;
      r.tick = 1'b0;
    end
    return r;
  endfunction

  // Out-of-range settings are clamped, never rejected; an undefined startMode falls back to START_ALWAYS
  always_comb begin
    cfg_next = cfgIn;
    if (cfgIn.searchVolts > VOLTS_MAX) begin
      cfg_next.searchVolts = VOLTS_MAX;
    end
    if (cfgIn.searchBoost > BOOST_MAX) begin
      cfg_next.searchBoost = BOOST_MAX;
    end
    if (cfgIn.searchTime < STIME_MIN) begin
      cfg_next.searchTime = STIME_MIN;
    end else if (cfgIn.searchTime > STIME_MAX) begin
      cfg_next.searchTime = STIME_MAX;
    end
    if (cfgIn.minSpeed > MINSPD_MAX) begin
      cfg_next.minSpeed = MINSPD_MAX;
    end
    if (cfgIn.refluxTime < RTIME_MIN) begin
      cfg_next.refluxTime = RTIME_MIN;
    end else if (cfgIn.refluxTime > RTIME_MAX) begin
      cfg_next.refluxTime = RTIME_MAX;
    end
    if (cfgIn.startMode > START_TRIP) begin
      cfg_next.startMode = START_ALWAYS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_reg <= CFG_RESET;
    end else if (cfgWrite) begin
      cfg_reg <= cfg_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfgOut <= CFG_RESET;
    end else begin
      cfgOut <= cfg_reg;
    end
  end

  assign sweepLimit  = 40'(cfg_reg.searchTime) * 40'(TIME_UNIT_CYC);
  assign refluxLimit = 40'(cfg_reg.refluxTime) * 40'(TIME_UNIT_CYC);
  assign minDeci     = 16'(cfg_reg.minSpeed) * HZ_TO_DECI;
  assign catchAllowed = machineIsInduction
                      && (vectorMode ? cfg_reg.vectorEnable
                                     : cfg_reg.vhzEnable);

  always_comb begin
    unique case (cfg_reg.startMode)
      START_TRIP_PWR: triggerMet = lastTrip_reg || powerUp_reg;
      START_TRIP:     triggerMet = lastTrip_reg;
      default:        triggerMet = 1'b1;
    endcase
  end

  assign regenEdge = motorRegenerating && !regenPrev_reg;
  // A zero floor would otherwise leave the sweep parked at 0 Hz
  assign belowMin  = (driveCmd.freq < minDeci)
                     || (driveCmd.freq == 16'h0000);

  always_comb begin
    if (state_reg == ST_REFLUX) begin
      dda_next = ddaStep(acc_reg, REFLUX_STEPS, refluxLimit);
    end else begin
      dda_next = ddaStep(acc_reg, maxFreq, sweepLimit);
    end
  end

  // Power-up counts as a stop condition until the first start
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      powerUp_reg  <= 1'b1;
      lastTrip_reg <= 1'b0;
    end else begin
      if (startRequest && state_reg == ST_STOPPED) begin
        powerUp_reg <= 1'b0;
      end
      if (stopRequest) begin
        lastTrip_reg <= stopUncontrolled;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regenPrev_reg <= 1'b0;
    end else begin
      regenPrev_reg <= motorRegenerating;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg      <= ST_STOPPED;
      secondPass_reg <= 1'b0;
      acc_reg        <= 40'h0000000000;
      driveCmd       <= '0;
      rampFromZero   <= 1'b0;
      catchSucceeded <= 1'b0;
    end else begin
      rampFromZero   <= 1'b0;
      catchSucceeded <= 1'b0;
      if (stopRequest) begin
        state_reg <= ST_STOPPED;
        driveCmd  <= '0;
      end else begin
        unique case (state_reg)
          ST_STOPPED: begin
            if (startRequest) begin
              acc_reg        <= 40'h0000000000;
              secondPass_reg <= 1'b0;
              driveCmd.reverse <= setpointReverse;
              if (catchAllowed && triggerMet) begin
                state_reg      <= ST_SEARCH;
                driveCmd.freq  <= maxFreq;
                driveCmd.volts <= cfg_reg.searchVolts;
                driveCmd.boost <= cfg_reg.searchBoost;
              end else begin
                state_reg      <= ST_RUN;
                driveCmd.freq  <= 16'h0000;
                driveCmd.volts <= WORK_VOLTS;
                driveCmd.boost <= 6'h00;
                rampFromZero   <= 1'b1;
              end
            end
          end
          ST_SEARCH: begin
            if (regenEdge) begin
              // Frequency held where the rotor was found
              state_reg      <= ST_REFLUX;
              acc_reg        <= 40'h0000000000;
              driveCmd.boost <= 6'h00;
            end else if (belowMin) begin
              acc_reg <= 40'h0000000000;
              if (cfg_reg.searchMode == SEARCH_BIDIR && !secondPass_reg) begin
                secondPass_reg   <= 1'b1;
                driveCmd.reverse <= !driveCmd.reverse;
                driveCmd.freq    <= maxFreq;
              end else begin
                // Unidirectional never gets a second pass
                state_reg      <= ST_RUN;
                driveCmd.freq  <= 16'h0000;
                driveCmd.reverse <= setpointReverse;
                driveCmd.volts <= WORK_VOLTS;
                driveCmd.boost <= 6'h00;
                rampFromZero   <= 1'b1;
              end
            end else begin
              acc_reg <= dda_next.acc;
              if (dda_next.tick && driveCmd.freq != 16'h0000) begin
                driveCmd.freq <= driveCmd.freq - 16'h0001;
              end
            end
          end
          ST_REFLUX: begin
            acc_reg <= dda_next.acc;
            if (driveCmd.volts >= WORK_VOLTS) begin
              state_reg      <= ST_RUN;
              driveCmd.volts <= WORK_VOLTS;
              catchSucceeded <= 1'b1;
            end else if (dda_next.tick) begin
              driveCmd.volts <= driveCmd.volts + 7'h01;
            end
          end
          ST_RUN: begin
          end
          default: begin
            state_reg <= ST_STOPPED;
          end
        endcase
      end
    end
  end

  // Status follows the sequencer one edge later, from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      motor_sequencer_state <= SEQ_STOPPED;
      catchActive           <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_SEARCH, ST_REFLUX: begin
          motor_sequencer_state <= SEQ_PRE_RUN;
          catchActive           <= 1'b1;
        end
        ST_RUN: begin
          motor_sequencer_state <= SEQ_NORMAL_RUN;
          catchActive           <= 1'b0;
        end
        default: begin
          motor_sequencer_state <= SEQ_STOPPED;
          catchActive           <= 1'b0;
        end
      endcase
    end
  end

  AST_NO_CATCH_NON_INDUCTION: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_STOPPED && startRequest && !stopRequest
      && !machineIsInduction |=> state_reg != ST_SEARCH)
    else $error("Search started without an induction motor");

  AST_VHZ_ENABLE_GATES: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_STOPPED && startRequest && !stopRequest && !vectorMode
      && !cfg_reg.vhzEnable |=> state_reg == ST_RUN && rampFromZero)
    else $error("V/Hz search ran while disabled");

  AST_VECTOR_ENABLE_GATES: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_STOPPED && startRequest && !stopRequest && vectorMode
      && !cfg_reg.vectorEnable |=> state_reg != ST_SEARCH)
    else $error("Vector search ran while disabled");

  AST_PRE_RUN_CODE: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH |=> motor_sequencer_state == SEQ_PRE_RUN)
    else $error("State code not pre-running during search");

  AST_ACTIVE_MATCHES: assert property (@(posedge clk_sys)
    disable iff (reset)
    catchActive == ($past(state_reg) == ST_SEARCH
                    || $past(state_reg) == ST_REFLUX))
    else $error("Catch status does not track the sequence");

  AST_TRIP_ONLY: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_STOPPED && startRequest && !stopRequest
      && cfg_reg.startMode == START_TRIP && !lastTrip_reg
      |=> state_reg == ST_RUN)
    else $error("Trip-only trigger searched after a controlled stop");

  AST_SEARCH_LEVELS: assert property (@(posedge clk_sys)
    disable iff (reset)
    $rose(state_reg == ST_SEARCH) |-> driveCmd.volts == cfg_reg.searchVolts
      && driveCmd.boost == cfg_reg.searchBoost && driveCmd.freq == maxFreq)
    else $error("Search did not start at max speed with search levels");

  AST_SWEEP_DOWN: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH && $past(state_reg) == ST_SEARCH
      && driveCmd.reverse == $past(driveCmd.reverse)
      |-> driveCmd.freq <= $past(driveCmd.freq))
    else $error("Search frequency rose during a pass");

  AST_REGEN_STOPS: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH && regenEdge && !stopRequest
      |=> state_reg == ST_REFLUX && $stable(driveCmd.freq))
    else $error("Regeneration did not end the search");

  AST_FAIL_RAMP: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH && !regenEdge && belowMin && !stopRequest
      && (secondPass_reg || cfg_reg.searchMode != SEARCH_BIDIR)
      |=> rampFromZero && driveCmd.freq == 16'h0000
      ##1 !catchActive)
    else $error("Failed search did not ramp from zero");

  AST_UNIDIR_NO_REVERSE: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH && !regenEdge && belowMin && !stopRequest
      && cfg_reg.searchMode != SEARCH_BIDIR |=> state_reg == ST_RUN)
    else $error("Unidirectional search tried the reverse direction");

  AST_BIDIR_REVERSE: assert property (@(posedge clk_sys)
    disable iff (reset)
    state_reg == ST_SEARCH && !regenEdge && belowMin && !stopRequest
      && cfg_reg.searchMode == SEARCH_BIDIR && !secondPass_reg
      |=> state_reg == ST_SEARCH && driveCmd.reverse != $past(driveCmd.reverse))
    else $error("Bidirectional search did not reverse");

endmodule // spinning_motor_speed_search

// file: hdl/spinning_catch_pkg.sv
// Notes on behaviour
// - Catch is offered only when the machine kind is an induction motor.
// - Volts-per-hertz catch enable, reset false, gates search in that mode.
// - Separate vector catch enable, reset false, gates search in that mode.
// - Sequencer state reads 4 while catching, 5 once the sequence completes.
// - Status output, reset false, true exactly while the catch sequence runs.
// - Trigger: 0 every start, 1 trip/coast/power-up, 2 trip/coast only.
// - Direction select: 0 bidirectional (reset value), 1 unidirectional.
// - Search voltage percent 0..100, default 9, applied during search.
// - Search boost percent 0..50, default 40, applied during search.
// - Search time 0.1..60 s, default 5, sets sweep rate; longer is slower.
// - Small search voltage applied while sweeping down from maximum speed.
// - Motoring to regenerating change ends the sweep as a success.
// - Search fails when frequency drops below min speed, 0..500 Hz, default 5.
// - After failure the output ramps from zero frequency to the setpoint.
// - After success voltage rises to working level at 100 percent per reflux time, default 3.
// - Bidirectional: search setpoint direction first, then reverse on failure.
// - Unidirectional: search setpoint direction only, never reverse.
package spinning_catch_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 10;
  // Search and reflux times count in tenths of a second
  localparam int unsigned TIME_UNIT_NS     = 100_000_000;
  localparam int unsigned TIME_UNIT_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;

  localparam logic [1:0] START_ALWAYS    = 2'h0;
  localparam logic [1:0] START_TRIP_PWR  = 2'h1;
  localparam logic [1:0] START_TRIP      = 2'h2;
  localparam logic       SEARCH_BIDIR    = 1'h0;

  localparam logic [6:0]  VOLTS_DEFAULT  = 7'h09;
  localparam logic [6:0]  VOLTS_MAX      = 7'h64;
  localparam logic [5:0]  BOOST_DEFAULT  = 6'h28;
  localparam logic [5:0]  BOOST_MAX      = 6'h32;
  localparam logic [9:0]  STIME_DEFAULT  = 10'h032;
  localparam logic [9:0]  STIME_MIN      = 10'h001;
  localparam logic [9:0]  STIME_MAX      = 10'h258;
  localparam logic [8:0]  MINSPD_DEFAULT = 9'h005;
  localparam logic [8:0]  MINSPD_MAX     = 9'h1F4;
  localparam logic [6:0]  RTIME_DEFAULT  = 7'h1E;
  localparam logic [6:0]  RTIME_MIN      = 7'h01;
  localparam logic [6:0]  RTIME_MAX      = 7'h64;
  localparam logic [6:0]  WORK_VOLTS     = 7'h64;
  localparam logic [15:0] HZ_TO_DECI     = 16'h000A;
  localparam logic [15:0] REFLUX_STEPS   = 16'h0064;

  localparam logic [3:0] SEQ_STOPPED     = 4'h0;
  localparam logic [3:0] SEQ_PRE_RUN     = 4'h4;
  localparam logic [3:0] SEQ_NORMAL_RUN  = 4'h5;

  typedef struct packed {
    logic       vhzEnable;
    logic       vectorEnable;
    logic [1:0] startMode;
    logic       searchMode;
    logic [6:0] searchVolts;
    logic [5:0] searchBoost;
    logic [9:0] searchTime;
    logic [8:0] minSpeed;
    logic [6:0] refluxTime;
  } catch_cfg_t;

  localparam catch_cfg_t CFG_RESET = '{
    vhzEnable:    1'h0,
    vectorEnable: 1'h0,
    startMode:    START_ALWAYS,
    searchMode:   SEARCH_BIDIR,
    searchVolts:  VOLTS_DEFAULT,
    searchBoost:  BOOST_DEFAULT,
    searchTime:   STIME_DEFAULT,
    minSpeed:     MINSPD_DEFAULT,
    refluxTime:   RTIME_DEFAULT
  };

  // Frequency in 0.1 Hz, voltage and boost in percent
  typedef struct packed {
    logic [15:0] freq;
    logic        reverse;
    logic [6:0]  volts;
    logic [5:0]  boost;
  } drive_cmd_t;

  typedef struct packed {
    logic [39:0] acc;
    logic        tick;
  } dda_t;

endpackage

// file: tb/motor_inverter_model.sv
`timescale 1ns/1ps
module motor_inverter_model
  import spinning_catch_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire drive_cmd_t  driveCmd,
  input  wire logic        catchActive,
  input  wire logic [15:0] motorFreq,
  input  wire logic        motorReverse,
  output logic             motorRegenerating
);
  // Field slower than the rotor in the same sense returns energy
  // A stalled rotor never regenerates, so every search on it fails
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      motorRegenerating <= 1'h0;
    end else begin
      motorRegenerating <= catchActive && (motorFreq != 16'h0000) &&
                           (driveCmd.reverse == motorReverse) &&
                           (driveCmd.freq < motorFreq);
    end
  end
endmodule // motor_inverter_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import spinning_catch_pkg::*;
  localparam logic [15:0] MAX_F = 16'h00C8;
  logic clk_sys, reset, cfgWrite, machineIsInduction, vectorMode;
  logic startRequest, stopRequest, stopUncontrolled, motorReverse;
  logic setpointReverse;
  logic motorRegenerating, catchActive, rampFromZero, catchSucceeded;
  logic [3:0] motor_sequencer_state;
  catch_cfg_t cfgIn, cfgOut, c;
  drive_cmd_t driveCmd;
  int failCount = 0;
  int nTests = 0;

  spinning_motor_speed_search #(.TIME_UNIT_CYC(10)) dut (
    .clk_sys(clk_sys), .reset(reset), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
    .machineIsInduction(machineIsInduction), .vectorMode(vectorMode),
    .startRequest(startRequest), .stopRequest(stopRequest),
    .stopUncontrolled(stopUncontrolled), .setpointReverse(setpointReverse),
    .maxFreq(MAX_F), .motorRegenerating(motorRegenerating),
    .cfgOut(cfgOut), .driveCmd(driveCmd),
    .motor_sequencer_state(motor_sequencer_state),
    .catchActive(catchActive), .rampFromZero(rampFromZero),
    .catchSucceeded(catchSucceeded));

  motor_inverter_model motor (
    .clk_sys(clk_sys), .reset(reset), .driveCmd(driveCmd),
    .catchActive(catchActive), .motorFreq(16'h0078),
    .motorReverse(motorReverse), .motorRegenerating(motorRegenerating));

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input bit ok, input string msg);
    nTests++;
    if (!ok) begin
      failCount++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic doReset();
    reset = 1'h1;
    step(8);
    reset = 1'h0;
    step(1);
    chk(cfgOut === CFG_RESET, "config defaults");
    chk(catchActive === 1'h0, "status after reset");
    $display("test reset done");
  endtask

  task automatic writeCfg(input catch_cfg_t v);
    cfgIn = v;
    cfgWrite = 1'h1;
    step(1);
    cfgWrite = 1'h0;
    step(2);
  endtask

  task automatic pulseStart();
    startRequest = 1'h1;
    step(1);
    startRequest = 1'h0;
    step(1);
  endtask

  task automatic stopRun(input logic unc);
    stopRequest = 1'h1;
    stopUncontrolled = unc;
    step(1);
    stopRequest = 1'h0;
    stopUncontrolled = 1'h0;
    step(3);
  endtask

  // Stops right after the decision, so the motor state never matters
  task automatic tryStart(input logic exp, input logic unc);
    pulseStart();
    step(1);
    chk(catchActive === exp, "search decision");
    chk(motor_sequencer_state === (exp ? SEQ_PRE_RUN : SEQ_NORMAL_RUN),
        "state after start");
    stopRun(unc);
    $display("test start decision done");
  endtask

  task automatic catchRun(input catch_cfg_t v, input logic mr);
    int n;
    int e;
    logic sawMax;
    logic [15:0] held;
    motorReverse = mr;
    writeCfg(v);
    pulseStart();
    chk(driveCmd.freq === MAX_F && driveCmd.reverse === 1'h0, "sweep");
    chk(driveCmd.volts === v.searchVolts, "search volts");
    chk(driveCmd.boost === v.searchBoost, "search boost");
    step(1);
    chk(motor_sequencer_state === SEQ_PRE_RUN, "pre-run");
    chk(catchActive === 1'h1, "active");
    n = 0;
    sawMax = 1'h0;
    while (motorRegenerating !== 1'h1 && n < 3000) begin
      step(1);
      n++;
      if (driveCmd.reverse === 1'h1 && driveCmd.freq === MAX_F) sawMax = 1'h1;
    end
    chk(sawMax === mr, "reverse pass");
    e = 81 * int'(v.searchTime) / 20;
    chk(mr || (n > e - 12 && n < e + 12), "sweep time");
    chk(driveCmd.freq < 16'h0078 && driveCmd.freq > 16'h006F, "caught");
    step(2);
    held = driveCmd.freq;
    step(5);
    chk(driveCmd.freq === held, "sweep stopped");
    chk(catchActive === 1'h1, "active in reflux");
    n = 0;
    while (catchSucceeded !== 1'h1 && n < 2000) begin
      step(1);
      n++;
    end
    e = (100 - int'(v.searchVolts)) * int'(v.refluxTime) / 10 - 7;
    chk(n > e - 12 && n < e + 12, "reflux time");
    chk(driveCmd.volts === WORK_VOLTS, "working volts");
    step(2);
    chk(motor_sequencer_state === SEQ_NORMAL_RUN, "run state");
    chk(catchActive === 1'h0, "status cleared");
    stopRun(1'h0);
    $display("test catch run done");
  endtask

  task automatic failRun(input logic sp);
    int n;
    logic sawRev;
    logic [15:0] lastF;
    c = CFG_RESET;
    c.vhzEnable = 1'h1;
    c.searchMode = 1'h1;
    c.minSpeed = 9'h008;
    motorReverse = !sp;
    setpointReverse = sp;
    writeCfg(c);
    pulseStart();
    n = 0;
    sawRev = 1'h0;
    lastF = driveCmd.freq;
    while (rampFromZero !== 1'h1 && n < 3000) begin
      lastF = driveCmd.freq;
      step(1);
      n++;
      if (driveCmd.reverse !== sp) sawRev = 1'h1;
    end
    chk(sawRev === 1'h0, "reverse search");
    chk(lastF < 16'h0050 && lastF > 16'h004B, "fail speed");
    chk(rampFromZero === 1'h1 && driveCmd.freq === 16'h0000, "ramp");
    step(1);
    chk(motor_sequencer_state === SEQ_NORMAL_RUN, "run state");
    chk(catchActive === 1'h0, "status cleared");
    stopRun(1'h0);
    $display("test failed search done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    failCount++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    results();
  end

  initial begin
    clk_sys = 1'h0;
    {reset, cfgWrite, startRequest, stopRequest, stopUncontrolled} = '0;
    {vectorMode, motorReverse, setpointReverse} = '0;
    machineIsInduction = 1'h1;
    cfgIn = CFG_RESET;
    doReset();
    c = CFG_RESET;
    c.vhzEnable = 1'h1;
    c.startMode = START_TRIP;
    writeCfg(c);
    tryStart(1'h0, 1'h0);
    tryStart(1'h0, 1'h1);
    tryStart(1'h1, 1'h0);
    c.startMode = START_TRIP_PWR;
    writeCfg(c);
    tryStart(1'h0, 1'h1);
    tryStart(1'h1, 1'h0);
    doReset();
    writeCfg(c);
    tryStart(1'h1, 1'h0);
    c.startMode = START_ALWAYS;
    writeCfg(c);
    tryStart(1'h1, 1'h0);
    vectorMode = 1'h1;
    tryStart(1'h0, 1'h0);
    c.vhzEnable = 1'h0;
    c.vectorEnable = 1'h1;
    writeCfg(c);
    tryStart(1'h1, 1'h0);
    vectorMode = 1'h0;
    tryStart(1'h0, 1'h0);
    c.vhzEnable = 1'h1;
    writeCfg(c);
    machineIsInduction = 1'h0;
    tryStart(1'h0, 1'h0);
    machineIsInduction = 1'h1;
    c = CFG_RESET;
    c.startMode = 2'h3;
    c.searchVolts = 7'h7F;
    c.searchBoost = 6'h3F;
    c.searchTime = 10'h000;
    c.minSpeed = 9'h1FF;
    c.refluxTime = 7'h7F;
    writeCfg(c);
    chk(cfgOut.startMode === START_ALWAYS, "mode clamp");
    chk(cfgOut.searchVolts === VOLTS_MAX, "volts clamp");
    chk(cfgOut.searchBoost === BOOST_MAX, "boost clamp");
    chk(cfgOut.searchTime === STIME_MIN, "time clamp");
    chk(cfgOut.minSpeed === MINSPD_MAX, "speed clamp");
    chk(cfgOut.refluxTime === RTIME_MAX, "reflux clamp");
    $display("test clamp done");
    c = CFG_RESET;
    c.vhzEnable = 1'h1;
    c.searchVolts = 7'h0C;
    c.searchBoost = 6'h14;
    catchRun(c, 1'h0);
    c.searchTime = 10'h064;
    catchRun(c, 1'h0);
    catchRun(c, 1'h1);
    failRun(1'h0);
    failRun(1'h1);
    results();
  end
endmodule // tb
